// [common/tssc_map.vh]
`ifndef TSSC_MAP_VH
`define TSSC_MAP_VH
// Output control latch address and bit positions
`define TSSC_OCL_ADDR 16'hFF7F
`define TSSC_OCL_HEATER 0
`define TSSC_OCL_PUMP 1
`define TSSC_OCL_HOT_VALVE 2
`define TSSC_OCL_COLD_VALVE 3
`define TSSC_OCL_ALARM 4
`define TSSC_OCL_COMPRESSOR 5
`define TSSC_OCL_LEADER_A 6
`define TSSC_OCL_LEADER_B 7
// Latch reset: all drives off (pins high)
`define TSSC_OCL_RESET 8'hFF
// Temperature thresholds in 0.1 degC units
`define TSSC_CUT_OUT_DC 12'h021
`define TSSC_CUT_IN_DC 12'h03A
// Flash period of alert/alarm toggle in ms
`define TSSC_FLASH_MS 250
`define TSSC_CLK_HZ 20000000
// 250 ms at 20 MHz, sized to the flash counter
`define TSSC_FLASH_CYC 24'h4C4B40
`endif

// [verilog/tssc_sync.v]
`timescale 1ns/1ps
// Three-stage synchroniser; change accepted when stages 2 and 3 agree
module tssc_sync (
	core_clk,
	sys_rst,
	async_in,
	sync_out
);
	input wire core_clk;
	input wire sys_rst;
	input wire async_in;
	output reg sync_out;
	reg s1_r;
	reg s2_r;
	reg s3_r;
	always @(posedge core_clk) begin
		if (sys_rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			s1_r <= async_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r)
				sync_out <= s3_r;
		end
	end
endmodule

// [verilog/tssc_ctrl.v]
`timescale 1ns/1ps
`include "tssc_map.vh"
module tssc_ctrl (
	core_clk,
	sys_rst,
	bus_addr,
	bus_wdata,
	bus_wr,
	reservoir_temp,
	temp_valid,
	internal_fault,
	fault_code,
	shutdown_signal_buffer,
	shutdown_sense_input,
	output_control_latch,
	shutdown_command_output,
	display_blank,
	alert_led,
	remove_from_use_led,
	alarm_drive,
	shutdown_active,
	shutdown_code
);
	input wire core_clk;
	input wire sys_rst;
	input wire [15:0] bus_addr;
	input wire [7:0] bus_wdata;
	input wire bus_wr;
	input wire [11:0] reservoir_temp;
	input wire temp_valid;
	input wire internal_fault;
	input wire [3:0] fault_code;
	input wire shutdown_signal_buffer;
	input wire shutdown_sense_input;
	output reg [7:0] output_control_latch;
	output reg shutdown_command_output;
	output reg display_blank;
	output reg alert_led;
	output reg remove_from_use_led;
	output reg alarm_drive;
	output reg shutdown_active;
	output reg [3:0] shutdown_code;

	localparam [1:0] ST_RUN = 2'b01;
	localparam [1:0] ST_SHUT = 2'b10;
	localparam [3:0] CODE_THERMOSTAT = 4'h1;
	localparam [23:0] FLASH_CYC = `TSSC_FLASH_CYC;

	wire sense_sync;
	wire buf_sync;
	reg [1:0] state_r;
	reg [7:0] sw_latch_r;
	reg comp_on_r;
	reg flash_r;
	reg [23:0] flash_cnt_r;
	reg [1:0] state_nxt;
	reg [7:0] ocl_nxt;

	// Active-low latch pin for a given write-one-to-enable bit
	function drv_pin;
		input en;
		begin
			drv_pin = ~en;
		end
	endfunction

	// Thermostat trip outranks an internal fault in the stored code
	function [3:0] sd_reason;
		input sense;
		input [3:0] code;
		begin
			if (sense)
				sd_reason = CODE_THERMOSTAT;
			else
				sd_reason = code;
		end
	endfunction

	// Both pins come from the power board, another domain
	tssc_sync u_sense (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.async_in(shutdown_sense_input),
		.sync_out(sense_sync)
	);

	tssc_sync u_buf (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.async_in(shutdown_signal_buffer),
		.sync_out(buf_sync)
	);

	// Software writes to the latch; drive bits are stored as enables
	always @(posedge core_clk) begin
		if (sys_rst)
			sw_latch_r <= 8'h00;
		else if (bus_wr && bus_addr == `TSSC_OCL_ADDR)
			sw_latch_r <= bus_wdata;
	end

	// Hysteresis: no change inside the band
	// Samples without temp_valid are ignored
	always @(posedge core_clk) begin
		if (sys_rst) begin
			comp_on_r <= 1'b0;
		end else if (temp_valid) begin
			if (reservoir_temp <= `TSSC_CUT_OUT_DC)
				comp_on_r <= 1'b0;
			else if (reservoir_temp >= `TSSC_CUT_IN_DC)
				comp_on_r <= 1'b1;
		end
	end

	// Only a reset (power cycle) leaves the shutdown state
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_RUN: begin
				if (sense_sync || internal_fault)
					state_nxt = ST_SHUT;
			end
			ST_SHUT: begin
				state_nxt = ST_SHUT;
			end
			default: begin
				state_nxt = ST_SHUT;
			end
		endcase
	end

	always @(posedge core_clk) begin
		if (sys_rst) begin
			state_r <= ST_RUN;
			shutdown_code <= 4'h0;
		end else begin
			state_r <= state_nxt;
			if (state_r == ST_RUN && state_nxt == ST_SHUT) begin
				shutdown_code <= sd_reason(sense_sync,
					fault_code);
			end
		end
	end

	// Counter idles outside shutdown so the first phase is a full one
	always @(posedge core_clk) begin
		if (sys_rst || state_r != ST_SHUT) begin
			flash_cnt_r <= 24'h000000;
			flash_r <= 1'b0;
		end else if (flash_cnt_r == FLASH_CYC - 24'h000001) begin
			flash_cnt_r <= 24'h000000;
			flash_r <= ~flash_r;
		end else begin
			flash_cnt_r <= flash_cnt_r + 24'h000001;
		end
	end

	always @* begin
		ocl_nxt = `TSSC_OCL_RESET;
		if (state_r == ST_RUN) begin
			ocl_nxt[`TSSC_OCL_HEATER] = drv_pin(sw_latch_r[`TSSC_OCL_HEATER]);
			ocl_nxt[`TSSC_OCL_PUMP] = drv_pin(sw_latch_r[`TSSC_OCL_PUMP]);
			ocl_nxt[`TSSC_OCL_HOT_VALVE] =
				drv_pin(sw_latch_r[`TSSC_OCL_HOT_VALVE]);
			ocl_nxt[`TSSC_OCL_COLD_VALVE] =
				drv_pin(sw_latch_r[`TSSC_OCL_COLD_VALVE]);
			ocl_nxt[`TSSC_OCL_ALARM] = sw_latch_r[`TSSC_OCL_ALARM];
			ocl_nxt[`TSSC_OCL_LEADER_A] = sw_latch_r[`TSSC_OCL_LEADER_A];
			ocl_nxt[`TSSC_OCL_LEADER_B] = sw_latch_r[`TSSC_OCL_LEADER_B];
			// Regulation decides, software bit must also permit
			ocl_nxt[`TSSC_OCL_COMPRESSOR] = drv_pin(comp_on_r &&
				sw_latch_r[`TSSC_OCL_COMPRESSOR]);
		end else begin
			// All drives off; alarm pin follows flashing
			ocl_nxt[`TSSC_OCL_ALARM] = ~flash_r;
		end
	end

	// Registered so every pin comes straight from a flip-flop
	always @(posedge core_clk) begin
		if (sys_rst) begin
			output_control_latch <= `TSSC_OCL_RESET;
			shutdown_command_output <= 1'b0;
			display_blank <= 1'b0;
			alert_led <= 1'b0;
			remove_from_use_led <= 1'b0;
			alarm_drive <= 1'b0;
			shutdown_active <= 1'b0;
		end else begin
			output_control_latch <= ocl_nxt;
			shutdown_active <= (state_r == ST_SHUT);
			shutdown_command_output <= (state_r == ST_SHUT);
			display_blank <= (state_r == ST_SHUT);
			if (state_r == ST_SHUT) begin
				alert_led <= flash_r;
				remove_from_use_led <= 1'b1;
				alarm_drive <= flash_r;
			end else begin
				// External signal lights without software action
				alert_led <= buf_sync;
				remove_from_use_led <= buf_sync;
				alarm_drive <= buf_sync |
					~sw_latch_r[`TSSC_OCL_ALARM];
			end
		end
	end
endmodule

// [dv/tssc_psb_model.sv]
`timescale 1ns/1ps
module tssc_psb_model (input wire core_clk, input wire breaker_off,
	input wire thermo_open, output reg shutdown_signal_buffer);
	// Trip holds after the thermostat recloses; only the breaker clears it
	always @(posedge core_clk)
		shutdown_signal_buffer <= !breaker_off &&
			(shutdown_signal_buffer || thermo_open);
endmodule

// [dv/tssc_ctrl_props.sv]
`timescale 1ns/1ps
module tssc_ctrl_props (
	input wire core_clk, sys_rst, bus_wr, temp_valid, internal_fault,
	input wire shutdown_sense_input, shutdown_signal_buffer, alert_led,
	input wire remove_from_use_led, shutdown_command_output, shutdown_active,
	input wire [15:0] bus_addr, input wire [11:0] reservoir_temp,
	input wire [7:0] bus_wdata, output_control_latch,
	input wire [3:0] fault_code, shutdown_code);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	wire hit = bus_wr && bus_addr == 16'hFF7F;
	wire [7:0] ocl = output_control_latch;
	wire sd = shutdown_active;
	a_latch_write: assert property (hit && !sd ##1 !hit [*3] |->
		sd || ocl[3:0] == ~$past(bus_wdata[3:0], 3)) else $error("bad write");
	a_addr_ignore: assert property (!hit [*4] ##0 !sd |=>
		$stable(ocl[3:0])) else $error("latch moved");
	a_forced_off: assert property (sd |=>
		&{ocl[7:5], ocl[3:0], shutdown_command_output, remove_from_use_led})
		else $error("drive on in shutdown");
	a_sd_sticky: assert property (sd |=> sd)
		else $error("left shutdown");
	a_fault_entry: assert property (internal_fault && !sd |=> ##1 sd &&
		shutdown_code == $past(fault_code, 2)) else $error("fault entry");
	a_sense_entry: assert property (shutdown_sense_input [*2] |->
		##[1:6] sd) else $error("sense entry");
	a_comp_cold: assert property ((temp_valid &&
		reservoir_temp <= 12'h021) [*6] |-> ocl[5]) else $error("comp on");
	a_leds_direct: assert property (shutdown_signal_buffer [*8] ##0 !sd
		|-> alert_led && remove_from_use_led) else $error("leds off");
	c_write: cover property (hit);
	c_fault: cover property (internal_fault && !sd);
	c_sense: cover property (shutdown_sense_input && !sd);
endmodule
bind tssc_ctrl tssc_ctrl_props props (.*);

// [dv/tssc_ctrl_bench.sv]
`timescale 1ns/1ps
module tssc_ctrl_bench;
	reg core_clk = 1'h0, sys_rst = 1'h1, bus_wr = 1'h0, flt = 1'h0;
	reg topen = 1'h0, sen = 1'h0, tv = 1'h1;
	reg [15:0] addr = 16'h0000;
	reg [7:0] wd = 8'h00;
	reg [11:0] tmp = 12'h014;
	wire sbuf, cmd, blank, alert, remove_from_use_condition, alarm, act;
	wire [7:0] ocl;
	wire [3:0] code;
	integer errors = 0, tests_run = 0;
	always #25 core_clk = ~core_clk;
	tssc_psb_model psb (.core_clk(core_clk), .breaker_off(sys_rst),
		.thermo_open(topen), .shutdown_signal_buffer(sbuf));
	tssc_ctrl dut (.core_clk(core_clk), .sys_rst(sys_rst), .bus_addr(addr),
		.bus_wdata(wd), .bus_wr(bus_wr), .reservoir_temp(tmp),
		.temp_valid(tv), .internal_fault(flt), .fault_code(4'h9),
		.shutdown_signal_buffer(sbuf), .shutdown_sense_input(sbuf & sen),
		.output_control_latch(ocl), .shutdown_command_output(cmd),
		.display_blank(blank), .alert_led(alert), .remove_from_use_led(remove_from_use_condition),
		.alarm_drive(alarm), .shutdown_active(act), .shutdown_code(code));
	task w(input integer n);
		repeat (n) @(negedge core_clk);
	endtask
	task chk(input [7:0] s, input [7:0] e);
		tests_run = tests_run + 1;
		errors = errors + (s !== e);
		if (s !== e) $display("[ERR] %0t got %h want %h", $time, s, e);
	endtask
	task wr(input [15:0] a, input [7:0] d);
		addr = a;
		wd = d;
		bus_wr = 1'h1;
		w(1);
		bus_wr = 1'h0;
		w(3);
	endtask
	task pwr;
		sys_rst = 1'h1;
		w(2);
		sys_rst = 1'h0;
	endtask
	task t(input [11:0] v, input e);
		tmp = v;
		w(8);
		chk({7'h0, ocl[5]}, {7'h0, e});
	endtask
	task finish_test;
		if (errors == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge core_clk);
		errors = errors + 1;
		finish_test;
	end
	initial begin
		pwr;
		wr(16'hFF7F, 8'h2F);
		chk({3'h0, ocl[5], ocl[3:0]}, 8'h10);
		wr(16'hFF7E, 8'h00);
		chk({4'h0, ocl[3:0]}, 8'h00);
		// Inside the band the compressor keeps its last state
		t(12'h028, 1'h1);
		t(12'h03A, 1'h0);
		t(12'h028, 1'h0);
		t(12'h021, 1'h1);
		tv = 1'h0;
		t(12'h03A, 1'h1);
		tv = 1'h1;
		flt = 1'h1;
		wr(16'hFF7F, 8'h2F);
		chk({act, cmd, blank, remove_from_use_condition, code}, 8'hF9);
		chk({3'h0, ocl[5], ocl[3:0]}, 8'h1F);
		chk({3'h0, alert, alarm, ocl[4], ocl[7:6]}, 8'h07);
		flt = 1'h0;
		pwr;
		topen = 1'h1;
		w(1);
		// Thermostat recloses; only the sense path is still blocked
		topen = 1'h0;
		w(12);
		chk({5'h0, alert, remove_from_use_condition, alarm}, 8'h07);
		sen = 1'h1;
		w(8);
		chk({act, cmd, 2'h0, code}, 8'hC1);
		topen = 1'h1;
		pwr;
		w(8);
		chk({7'h0, act}, 8'h01);
		finish_test;
	end
endmodule
